//--- design/link_test_ctrl.sv
`timescale 1ns/1ns
`include "link_test_map.svh"
module link_test_ctrl
    import link_test_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [15:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire lane_data_t  data_in,
    output lane_data_t       data_out,
    input  wire logic        sync_request_input,
    input  wire logic        lmfc_boundary,
    output logic             send_sync_chars,
    output logic             align_start,
    output logic [7:0]       checksum
);

    // Software-visible state.
    logic [1:0]  option_r;     // Bit 1 inverts symbols, bit 0 powers the link down.
    logic [1:0]  option_nxt;   // Next option value.
    ctrl3_t      ctrl3_r;      // Checksum mode, injection point and pattern.
    ctrl3_t      ctrl3_nxt;    // Next control value.
    logic [3:0]  delay_r;      // Alignment delay in boundaries minus one.
    logic [3:0]  delay_nxt;    // Next delay value.
    logic [15:0] user_r;       // User test word.
    logic [15:0] user_nxt;     // Next user word.
    logic [31:0] cfg_r;        // Link configuration table, four bytes.
    logic [31:0] cfg_nxt;      // Next configuration table.

    // Bus answer state.
    logic [31:0] prdata_r;     // Registered read data.
    logic [31:0] prdata_nxt;   // Next read data.
    logic        pready_r;     // Registered ready.
    logic        pready_nxt;   // Next ready.
    logic        pslverr_r;    // Registered error.
    logic        pslverr_nxt;  // Next error.

    // Decoded access.
    logic        hit_opt;      // Option register selected.
    logic        hit_c3;       // Control 3 selected.
    logic        hit_c4;       // Control 4 selected.
    logic        hit_user;     // User word selected.
    logic        hit_cfg;      // Configuration table selected.
    logic        hit_stat;     // Status selected.
    logic        mapped;       // Any register selected.
    logic        wr_go;        // Write takes effect this edge.

    // Pattern and link state.
    logic [30:0] pn_r;         // Shared PN shift register.
    logic [30:0] pn_nxt;       // Next PN state.
    logic [15:0] pat_r;        // Current pattern word.
    logic [15:0] pat_nxt;      // Next pattern word.
    logic        phase_r;      // Alternation phase for toggling patterns.
    logic        phase_nxt;    // Next phase.
    logic        once_r;       // Single user word already sent.
    logic        once_nxt;     // Next single-shot flag.
    logic [3:0]  last_pat_r;   // Pattern code seen last cycle.
    link_state_t state_r;      // Link sequencing state.
    link_state_t state_nxt;    // Next link state.
    logic [3:0]  bcnt_r;       // Boundaries counted since release.
    logic [3:0]  bcnt_nxt;     // Next boundary count.
    logic        start_r;      // Alignment start pulse.
    logic        start_nxt;    // Next start pulse.
    logic        cgs_r;        // Synchronization characters requested.
    logic        cgs_nxt;      // Next request.
    lane_data_t  out_r;        // Registered datapath.
    lane_data_t  out_nxt;      // Next datapath.
    logic [7:0]  ck_r;         // Registered checksum.
    logic [7:0]  ck_nxt;       // Next checksum.

    // One Fibonacci step of an n-bit PN register tapped at n and t.
    function automatic logic [30:0] pn_step(input logic [30:0] s,
                                            input logic [4:0]  n,
                                            input logic [4:0]  t);
        logic        fb;
        logic [30:0] mask;
        fb   = s[n - 5'd1] ^ s[t - 5'd1];
        mask = (31'h0000_0001 << n) - 31'h0000_0001;
        return ({s[29:0], fb}) & mask;
    endfunction : pn_step

    // Address decode; a word access only, low address bits must be zero.
    always_comb
    begin
        hit_opt  = (paddr[15:2] == `IDX_OPTION) && (paddr[1:0] == 2'h0);
        hit_c3   = (paddr[15:2] == `IDX_CTRL3)  && (paddr[1:0] == 2'h0);
        hit_c4   = (paddr[15:2] == `IDX_CTRL4)  && (paddr[1:0] == 2'h0);
        hit_user = (paddr[15:2] == `IDX_USER)   && (paddr[1:0] == 2'h0);
        hit_cfg  = (paddr[15:2] == `IDX_CFG)    && (paddr[1:0] == 2'h0);
        hit_stat = (paddr[15:2] == `IDX_STATUS) && (paddr[1:0] == 2'h0);
        mapped   = hit_opt | hit_c3 | hit_c4 | hit_user | hit_cfg | hit_stat;
        wr_go    = psel & penable & pready_r & pwrite & mapped;
    end

    // Bus answer: one wait state; read data is registered at the same edge that raises ready.
    always_comb
    begin
        pready_nxt  = psel & penable & ~pready_r;
        prdata_nxt  = prdata_r;
        pslverr_nxt = 1'b0;
        if (psel && penable && !pready_r)
        begin
            // Unmapped addresses answer with an error and zero data.
            pslverr_nxt = ~mapped;
            prdata_nxt  = 32'h0000_0000;
            if (hit_opt)
                prdata_nxt[1:0] = option_r;
            else if (hit_c3)
                prdata_nxt[7:0] = ctrl3_r;
            else if (hit_c4)
                prdata_nxt[7:4] = delay_r;
            else if (hit_user)
                prdata_nxt[15:0] = user_r;
            else if (hit_cfg)
                prdata_nxt = cfg_r;
            else if (hit_stat)
                prdata_nxt[11:0] = {state_r, ck_r};
        end
    end

    // Register writes; reserved bits are dropped and read back as zero.
    always_comb
    begin
        option_nxt = option_r;
        ctrl3_nxt  = ctrl3_r;
        delay_nxt  = delay_r;
        user_nxt   = user_r;
        cfg_nxt    = cfg_r;
        if (wr_go)
        begin
            if (hit_opt)
                option_nxt = pwdata[1:0];
            if (hit_c3)
                ctrl3_nxt = pwdata[7:0];
            if (hit_c4)
                delay_nxt = pwdata[`POS_DELAY_LO +: 4];
            if (hit_user)
                user_nxt = pwdata[15:0];
            if (hit_cfg)
                cfg_nxt = pwdata;
        end
    end

    // Checksum of the configuration table, truncated to a byte.
    always_comb
    begin
        logic [9:0] sum;
        sum = 10'h000;
        case (ctrl3_r.mode)
            CK_BYTES:
                sum = 10'(cfg_r[7:0]) + 10'(cfg_r[15:8])
                    + 10'(cfg_r[23:16]) + 10'(cfg_r[31:24]);
            CK_FIELDS:
                sum = 10'(cfg_r[4:0]) + 10'(cfg_r[7:5]) + 10'(cfg_r[15:8])
                    + 10'(cfg_r[20:16]) + 10'(cfg_r[23:21]) + 10'(cfg_r[31:24]);
            CK_ZERO:
                sum = 10'h000;
            default:
                sum = 10'h000;
        endcase
        ck_nxt = sum[7:0];
    end

    // Pattern generator. A code change restarts every pattern from its seed,
    // so a receiver checker can lock on a known starting point.
    always_comb
    begin
        pn_nxt    = pn_r;
        pat_nxt   = 16'h0000;
        phase_nxt = ~phase_r;
        once_nxt  = once_r;
        if (ctrl3_r.pat != last_pat_r)
        begin
            pn_nxt    = `PN_SEED;
            phase_nxt = 1'b0;
            once_nxt  = 1'b0;
            pat_nxt   = 16'h0000;
        end
        else
        begin
            case (ctrl3_r.pat)
                4'h1: pat_nxt = phase_r ? ~`WORD_CHECK : `WORD_CHECK;
                4'h2: pat_nxt = phase_r ? ~`WORD_ONES : `WORD_ONES;
                4'h3: pn_nxt  = pn_step(pn_r, 5'd31, 5'd28);
                4'h4: pn_nxt  = pn_step(pn_r, 5'd23, 5'd18);
                4'h5: pn_nxt  = pn_step(pn_r, 5'd15, 5'd14);
                4'h6: pn_nxt  = pn_step(pn_r, 5'd9,  5'd5);
                4'h7: pn_nxt  = pn_step(pn_r, 5'd7,  5'd6);
                4'h8: pat_nxt = pat_r + 16'h0001;
                4'hE: pat_nxt = user_r;
                4'hF:
                begin
                    // Single user word: sent once, then the lane idles at zero.
                    pat_nxt  = once_r ? 16'h0000 : user_r;
                    once_nxt = 1'b1;
                end
                default: pat_nxt = 16'h0000;
            endcase
            if ((ctrl3_r.pat >= 4'h3) && (ctrl3_r.pat <= 4'h7))
                pat_nxt = pn_nxt[15:0];
        end
    end

    // Link sequencing against the receiver's sync request.
    always_comb
    begin
        state_nxt = state_r;
        bcnt_nxt  = bcnt_r;
        start_nxt = 1'b0;
        cgs_nxt   = 1'b0;
        case (state_r)
            ST_OFF:
            begin
                if (!option_r[`POS_PDOWN])
                    state_nxt = ST_CGS;
            end
            ST_CGS:
            begin
                cgs_nxt  = sync_request_input;
                bcnt_nxt = 4'h0;
                if (!sync_request_input)
                    state_nxt = ST_WAIT;
            end
            ST_WAIT:
            begin
                // Count boundaries; the n+1-th one after release starts alignment.
                if (lmfc_boundary)
                begin
                    if (bcnt_r == delay_r)
                    begin
                        start_nxt = 1'b1;
                        state_nxt = ST_DATA;
                    end
                    else
                        bcnt_nxt = bcnt_r + 4'h1;
                end
            end
            ST_DATA:
            begin
                state_nxt = state_r;
            end
            default:
                state_nxt = ST_OFF;
        endcase
        // A renewed request sends the link back to synchronization at once.
        if ((state_r != ST_OFF) && sync_request_input)
        begin
            state_nxt = ST_CGS;
            cgs_nxt   = 1'b1;
            start_nxt = 1'b0;
        end
        if (option_r[`POS_PDOWN])
        begin
            state_nxt = ST_OFF;
            cgs_nxt   = 1'b0;
            start_nxt = 1'b0;
        end
    end

    // Datapath: inject the pattern at the chosen point, then invert symbols.
    always_comb
    begin
        out_nxt = data_in;
        if (ctrl3_r.pat != 4'h0)
        begin
            case (ctrl3_r.inj)
                INJ_SAMPLE: out_nxt.sample = pat_r;
                INJ_SYMBOL: out_nxt.symbol = pat_r[9:0];
                INJ_SCRAM:  out_nxt.scram  = pat_r[7:0];
                default:    out_nxt = data_in;
            endcase
        end
        if (option_r[`POS_INVERT])
            out_nxt.symbol = ~out_nxt.symbol;
    end

    // All state registers; the async reset loads constants only.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            option_r   <= `RST_OPTION;
            ctrl3_r    <= `RST_CTRL3;
            delay_r    <= `RST_DELAY;
            user_r     <= `RST_USER;
            cfg_r      <= `RST_CFG;
            prdata_r   <= 32'h0000_0000;
            pready_r   <= 1'b0;
            pslverr_r  <= 1'b0;
            pn_r       <= `PN_SEED;
            pat_r      <= 16'h0000;
            phase_r    <= 1'b0;
            once_r     <= 1'b0;
            last_pat_r <= 4'h0;
            state_r    <= ST_OFF;
            bcnt_r     <= 4'h0;
            start_r    <= 1'b0;
            cgs_r      <= 1'b0;
            out_r      <= '0;
            ck_r       <= 8'h00;
        end
        else
        begin
            option_r   <= option_nxt;
            ctrl3_r    <= ctrl3_nxt;
            delay_r    <= delay_nxt;
            user_r     <= user_nxt;
            cfg_r      <= cfg_nxt;
            prdata_r   <= prdata_nxt;
            pready_r   <= pready_nxt;
            pslverr_r  <= pslverr_nxt;
            pn_r       <= pn_nxt;
            pat_r      <= pat_nxt;
            phase_r    <= phase_nxt;
            once_r     <= once_nxt;
            last_pat_r <= ctrl3_r.pat;
            state_r    <= state_nxt;
            bcnt_r     <= bcnt_nxt;
            start_r    <= start_nxt;
            cgs_r      <= cgs_nxt;
            out_r      <= out_nxt;
            ck_r       <= ck_nxt;
        end
    end

    // Outputs come straight from the registers above.
    assign prdata          = prdata_r;
    assign pready          = pready_r;
    assign pslverr         = pslverr_r;
    assign data_out        = out_r;
    assign send_sync_chars = cgs_r;
    assign align_start     = start_r;
    assign checksum        = ck_r;

endmodule : link_test_ctrl

//--- design/link_test_map.svh
`ifndef LINK_TEST_MAP_SVH
`define LINK_TEST_MAP_SVH

// Register indices; the byte address is four times the index.
`define IDX_OPTION     14'h0572
`define IDX_CTRL3      14'h0573
`define IDX_CTRL4      14'h0574
`define IDX_USER       14'h05A0
`define IDX_CFG        14'h05A1
`define IDX_STATUS     14'h05A2

// Reset values.
`define RST_OPTION     2'h0
`define RST_CTRL3      8'h00
`define RST_DELAY      4'h0
`define RST_USER       16'h0000
`define RST_CFG        32'h0000_0000

// Field positions.
`define POS_INVERT     1
`define POS_PDOWN      0
`define POS_DELAY_LO   4
`define POS_STATE_LO   8

// Test word constants.
`define WORD_CHECK     16'hAAAA
`define WORD_ONES      16'hFFFF
`define PN_SEED        31'h7FFF_FFFF
`endif

//--- design/link_test_pkg.sv
package link_test_pkg;
    // Checksum selection.
    typedef enum logic [1:0] {
        CK_BYTES  = 2'h0,
        CK_FIELDS = 2'h1,
        CK_ZERO   = 2'h2,
        CK_UNUSED = 2'h3
    } ck_mode_t;

    // Where the generated pattern enters the transmit path.
    typedef enum logic [1:0] {
        INJ_SAMPLE = 2'h0,
        INJ_SYMBOL = 2'h1,
        INJ_SCRAM  = 2'h2,
        INJ_NONE   = 2'h3
    } inj_point_t;

    // Layout of the checksum and test pattern control register.
    typedef struct packed {
        ck_mode_t   mode;
        inj_point_t inj;
        logic [3:0] pat;
    } ctrl3_t;

    // Link sequencing states, one-hot.
    typedef enum logic [3:0] {
        ST_OFF  = 4'h1,
        ST_CGS  = 4'h2,
        ST_WAIT = 4'h4,
        ST_DATA = 4'h8
    } link_state_t;

    // Datapath samples travelling together.
    typedef struct packed {
        logic [15:0] sample;
        logic [7:0]  scram;
        logic [9:0]  symbol;
    } lane_data_t;
endpackage : link_test_pkg

//--- verif/link_rx_model.sv
`timescale 1ns/1ns
module link_rx_model
#(
    parameter int PERIOD = 8  // Cycles per multiframe.
)
(
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       want_sync,
    output logic            sync_request_input,
    output logic            lmfc_boundary,
    output logic      [7:0] bnd_cnt
);
    int   div;     // Multiframe divider.
    logic sync_d;  // Request one cycle back.
    // Only boundaries after a whole released cycle count, as the sender needs one
    // cycle to leave synchronisation before it can see them.
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sync_request_input <= 1'b1;
            sync_d             <= 1'b1;
            lmfc_boundary      <= 1'b0;
            div                <= 0;
            bnd_cnt            <= 8'h00;
        end
        else
        begin
            sync_request_input <= want_sync;
            sync_d             <= sync_request_input;
            div                <= (div + 1) % PERIOD;
            lmfc_boundary      <= (div == PERIOD - 1);
            if (sync_request_input)
                bnd_cnt <= 8'h00;
            else if (lmfc_boundary && !sync_d)
                bnd_cnt <= bnd_cnt + 8'h01;
        end
    end
endmodule : link_rx_model

//--- verif/link_test_ctrl_sva.sv
`timescale 1ns/1ns
module link_test_ctrl_sva
    import link_test_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire lane_data_t  data_in,
    input wire lane_data_t  data_out,
    input wire logic        sync_request_input,
    input wire logic        lmfc_boundary,
    input wire logic        send_sync_chars,
    input wire logic        align_start,
    input wire logic [7:0]  checksum
);
    logic [9:0] sh_r;    // Shadow of option bits over the control fields.
    logic [9:0] sh_nxt;  // Next shadow value.
    // The shadow follows completed writes, so it changes at the same edge as the design.
    always_comb
    begin
        sh_nxt = sh_r;
        if (psel && penable && pready && pwrite && paddr == 16'h15CC)
            sh_nxt[7:0] = pwdata[7:0];
        if (psel && penable && pready && pwrite && paddr == 16'h15C8)
            sh_nxt[9:8] = pwdata[1:0];
    end
    // Registers the shadow.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            sh_r <= 10'h000;
        else
            sh_r <= sh_nxt;
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_wait;
        psel && penable && !pready;
    endsequence
    property p_ready;
        $rose(penable) && psel |-> s_wait ##1 pready ##1 !pready;
    endproperty
    a_ready: assert property (p_ready) else $error("pready timing wrong");
    property p_sync_off;
        !sync_request_input |=> !send_sync_chars;
    endproperty
    a_sync_off: assert property (p_sync_off) else $error("sync chars unrequested");
    property p_align_cause;
        align_start |-> $past(lmfc_boundary) && !$past(sync_request_input);
    endproperty
    a_align_cause: assert property (p_align_cause) else $error("align off boundary");
    property p_align_pulse;
        align_start |=> !align_start [*3];
    endproperty
    a_align_pulse: assert property (p_align_pulse) else $error("align not a pulse");
    property p_normal;
        sh_r[3:0] == 4'h0 && sh_r[9:8] == 2'h0 |=> data_out == $past(data_in);
    endproperty
    a_normal: assert property (p_normal) else $error("normal data altered");
    property p_invert;
        sh_r[3:0] == 4'h0 && sh_r[9:8] == 2'h2 |=> data_out.symbol == ~$past(data_in.symbol);
    endproperty
    a_invert: assert property (p_invert) else $error("symbol not inverted");
    property p_checker;
        (sh_r[5:0] == 6'h01) [*4] |-> data_out.sample inside {16'hAAAA, 16'h5555}
            && data_out.sample != $past(data_out.sample);
    endproperty
    a_checker: assert property (p_checker) else $error("checkerboard wrong");
    property p_toggle;
        (sh_r == 10'h012) [*4] |-> data_out.symbol inside {10'h3FF, 10'h000}
            && data_out.symbol != $past(data_out.symbol);
    endproperty
    a_toggle: assert property (p_toggle) else $error("toggle at encoder wrong");
endmodule : link_test_ctrl_sva
bind link_test_ctrl link_test_ctrl_sva u_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .data_in(data_in), .data_out(data_out),
    .sync_request_input(sync_request_input), .lmfc_boundary(lmfc_boundary),
    .send_sync_chars(send_sync_chars), .align_start(align_start), .checksum(checksum));

//--- verif/serial_link_test_and_ilas_control_tb_top.sv
`timescale 1ns/1ns
module serial_link_test_and_ilas_control_tb_top
    import link_test_pkg::*;
;
    logic        pclk, presetn, psel, penable, pwrite, want_sync;
    logic [15:0] paddr, w;
    logic [31:0] pwdata, prdata, rd;
    logic        pready, pslverr, er, sync_request_input, lmfc_boundary;
    logic        send_sync_chars, align_start;
    logic [7:0]  checksum, bnd_cnt;
    lane_data_t  data_in = '0;  // Path stimulus; only the stepping process drives it.
    lane_data_t  data_out;
    int          error_cnt, compares, cyc, k;
    logic [7:0]  ck_exp [4] = '{8'h94, 8'h9C, 8'h00, 8'h00};  // Sums of 12_34_56_F8.
    logic [3:0]  dly [3] = '{4'h0, 4'h1, 4'hB};
    int          pn_n [5] = '{31, 23, 15, 9, 7};
    int          pn_t [5] = '{28, 18, 14, 5, 6};

    link_test_ctrl u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .data_in(data_in), .data_out(data_out),
        .sync_request_input(sync_request_input), .lmfc_boundary(lmfc_boundary),
        .send_sync_chars(send_sync_chars), .align_start(align_start), .checksum(checksum));
    link_rx_model u_rx (.pclk(pclk), .presetn(presetn), .want_sync(want_sync),
        .sync_request_input(sync_request_input), .lmfc_boundary(lmfc_boundary),
        .bnd_cnt(bnd_cnt));

    initial
    begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    // Path data moves every cycle so a stuck register shows; symbol steps by 10'h345.
    always @(posedge pclk)
        data_in <= lane_data_t'(data_in + 34'h1_2345);
    // A hang is cut short well beyond the few hundred cycles the run needs.
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            error_cnt++;
            final_report();
        end
    end

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask : tick

    // One APB transfer; the request stands until pready is seen high.
    task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        // No wait count is assumed; only the bench timeout ends a stalled transfer.
        while (pready !== 1'b1)
            @(posedge pclk);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Locks onto the first word shifted out of the all-ones seed, then follows the generator.
    task automatic pn_check(input int n, input int t);
        logic [30:0] st;
        logic [30:0] mask;
        int          m;
        mask = 31'h7FFF_FFFF >> (31 - n);
        st   = mask;
        // The seed word itself is never shown on the lane, only the states after it.
        st   = ((st << 1) | 31'(st[n-1] ^ st[t-1])) & mask;
        m    = 0;
        while (data_out.sample !== st[15:0] && m < 8)
        begin
            @(posedge pclk);
            m++;
        end
        for (int j = 0; j < 24; j++)
        begin
            st = ((st << 1) | 31'(st[n-1] ^ st[t-1])) & mask;
            @(posedge pclk);
            chk("pn_word", {16'h0000, st[15:0]}, {16'h0000, data_out.sample});
        end
    endtask : pn_check

    task automatic final_report();
        if (error_cnt == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : final_report

    initial
    begin
        presetn   = 1'b0;
        psel      = 1'b0;
        penable   = 1'b0;
        pwrite    = 1'b0;
        paddr     = 16'h0000;
        pwdata    = 32'h0000_0000;
        want_sync = 1'b1;
        tick(4);
        presetn <= 1'b1;
        apb(1'b0, 16'h15CC, 32'h0000_0000);
        chk("ctrl3_reset", 32'h0000_0000, rd);
        apb(1'b1, 16'h15D0, 32'hFFFF_FFFF);
        apb(1'b0, 16'h15D0, 32'h0000_0000);
        chk("ctrl4_rw", 32'h0000_00F0, rd);
        apb(1'b0, 16'h1000, 32'h0000_0000);
        chk("unmapped", 32'h0000_0000, rd | {31'h0, ~er});
        apb(1'b0, 16'h15CD, 32'h0000_0000);
        chk("misaligned", 32'h0000_0000, rd | {31'h0, ~er});
        // Every checksum mode over one table whose byte sum carries past bit 7.
        apb(1'b1, 16'h1684, 32'h1234_56F8);
        for (int m = 0; m < 4; m++)
        begin
            apb(1'b1, 16'h15CC, {24'h0, m[1:0], 6'h00});
            tick(2);
            chk("checksum", {24'h0, ck_exp[m]}, {24'h0, checksum});
        end
        for (int i = 0; i < 5; i++)
        begin
            apb(1'b1, 16'h15CC, 32'h0000_0000);
            apb(1'b1, 16'h15CC, 32'h0000_0003 + i);
            pn_check(pn_n[i], pn_t[i]);
        end
        apb(1'b1, 16'h15CC, 32'h0000_0008);
        tick(3);
        for (int j = 0; j < 4; j++)
        begin
            w = data_out.sample;
            tick(1);
            chk("ramp", {16'h0, w + 16'h0001}, {16'h0, data_out.sample});
        end
        apb(1'b1, 16'h15CC, 32'h0000_0001);
        tick(8);
        apb(1'b1, 16'h15CC, 32'h0000_0012);
        tick(8);
        apb(1'b1, 16'h1680, 32'h0000_BEEF);
        apb(1'b1, 16'h15CC, 32'h0000_000E);
        tick(4);
        chk("user_sample", 32'h0000_BEEF, {16'h0, data_out.sample});
        apb(1'b1, 16'h15CC, 32'h0000_001E);
        tick(4);
        chk("user_symbol", 32'h0000_02EF, {22'h0, data_out.symbol});
        apb(1'b1, 16'h15CC, 32'h0000_002E);
        tick(4);
        chk("user_scram", 32'h0000_00EF, {24'h0, data_out.scram});
        apb(1'b1, 16'h15CC, 32'h0000_003E);
        tick(2);
        chk("no_inject", {22'h0, data_in.symbol - 10'h345}, {22'h0, data_out.symbol});
        apb(1'b1, 16'h15CC, 32'h0000_000F);
        tick(4);
        chk("user_single", 32'h0000_BEEF, {16'h0, data_out.sample});
        tick(2);
        chk("user_single", 32'h0000_0000, {16'h0, data_out.sample});
        apb(1'b1, 16'h15CC, 32'h0000_0010);
        tick(2);
        chk("normal", {22'h0, data_in.symbol - 10'h345}, {22'h0, data_out.symbol});
        apb(1'b1, 16'h15C8, 32'h0000_0002);
        tick(2);
        chk("invert", {22'h0, ~(data_in.symbol - 10'h345)}, {22'h0, data_out.symbol});
        apb(1'b1, 16'h15C8, 32'h0000_0000);
        // Release the request for the first, second and twelfth boundary.
        for (int i = 0; i < 3; i++)
        begin
            want_sync <= 1'b1;
            apb(1'b1, 16'h15D0, {24'h0, dly[i], 4'h0});
            tick(3);
            chk("sync_chars", 32'h0000_0001, {31'h0, send_sync_chars});
            want_sync <= 1'b0;
            k = 0;
            while (align_start !== 1'b1 && k < 300)
            begin
                tick(1);
                k++;
            end
            chk("align_bound", {28'h0, dly[i]} + 32'h1, {24'h0, bnd_cnt});
        end
        // Status shows the data state and the mode 00 checksum of the table.
        apb(1'b0, 16'h1688, 32'h0000_0000);
        chk("status", 32'h0000_0894, rd);
        final_report();
    end
endmodule : serial_link_test_and_ilas_control_tb_top
